/* File: verilog/arf_top.sv */
// Purpose: converter result registers, done/ready/overrun flags, dma and irq
// Assumes: register port strobes one cycle wide, read data one cycle later
// Notes:   unmapped reads return zero, unmapped writes are ignored
// Operation
// - results come in full 12-bit or reduced 10-bit resolution
// - reset selects full resolution; the low-resolution bit picks 10-bit
// - reduced results sit right-aligned in the low bits
// - reduced mode: two top result bits read zero everywhere
// - dma requests are sized 16 bits in both resolutions
// - each result goes to its channel register and the last-result register
// - with tagging on, last-result register shows the channel number
// - each conversion sets its channel done flag and the ready flag
// - a rising ready flag raises a dma request
// - channel conversion, ready and global overrun events can raise the interrupt
// - reading a channel result clears that channel's done flag
// - reading last result clears ready and last channel's done flag
// - new result before old one read sets channel overrun
// - conversion while ready is set sets global overrun
// - reading overrun status clears all channel overrun flags
// - reading converter status clears global overrun
//
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module arf_top
  import arf_pkg::*;
#(
  parameter int unsigned NCH = 16
)
(
  input  wire logic      mclk_i,        // clock
  input  wire logic      srst_i,        // sync reset
  input  wire arf_bus_s  bus_i,         // register requests
  output var  logic [DW-1:0] rdata_o,   // read data
  input  wire logic      conv_valid_i,  // conversion done pulse
  input  wire arf_conv_s conv_i,        // channel and raw result
  output var  logic      irq_o,         // interrupt level
  output var  logic      dma_req_o,     // dma request pulse
  output var  logic [1:0] dma_size_o    // dma transfer size
);

  localparam int unsigned IW = NCH + 2;

  logic               low_res_reg;
  logic               tag_reg;
  logic [RES_W-1:0]   res_mem [NCH];
  logic [RES_W-1:0]   last_val_reg;
  logic [CH_W-1:0]    last_ch_reg;
  logic [IW-1:0]      imask_reg;
  logic               ready_q_reg;
  logic [NCH-1:0]     done;
  logic [NCH-1:0]     ovr;
  logic [IW-1:0]      istat;
  logic               ready;
  logic               gover;

  // decode
  wire logic rd_mr   = bus_i.rd && (bus_i.addr == MR_OFS);
  wire logic rd_emr  = bus_i.rd && (bus_i.addr == EMR_OFS);
  wire logic rd_sr   = bus_i.rd && (bus_i.addr == SR_OFS);
  wire logic rd_lcdr = bus_i.rd && (bus_i.addr == LCDR_OFS);
  wire logic rd_imr  = bus_i.rd && (bus_i.addr == IMR_OFS);
  wire logic rd_isr  = bus_i.rd && (bus_i.addr == ISR_OFS);
  wire logic rd_over = bus_i.rd && (bus_i.addr == OVER_OFS);
  wire logic wr_mr   = bus_i.wr && (bus_i.addr == MR_OFS);
  wire logic wr_emr  = bus_i.wr && (bus_i.addr == EMR_OFS);
  wire logic wr_imr  = bus_i.wr && (bus_i.addr == IMR_OFS);

  wire logic [AW-1:0]   cdr_off = bus_i.addr - CDR_BASE;
  wire logic [CH_W-1:0] cdr_idx = cdr_off[CH_W+1:2];
  wire logic cdr_in = (bus_i.addr >= CDR_BASE) && (cdr_off[AW-1:CH_W+2] == '0)
                      && (cdr_off[1:0] == 2'h0) && (32'(cdr_idx) < NCH);
  wire logic rd_cdr = bus_i.rd && cdr_in;

  // formatted result
  logic [RES_W-1:0] fmt_res;

  arf_fmt #(
    .FULL_W (RES_W),
    .RED_W  (LOW_W)
  ) u_fmt (
    .low_res_i (low_res_reg),
    .raw_i     (conv_i.data),
    .res_o     (fmt_res)
  );

  // per-channel flags
  logic [NCH-1:0] conv_hit;
  logic [NCH-1:0] done_clr;

  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    assign conv_hit[i] = conv_valid_i && (32'(conv_i.chan) == i);
    assign done_clr[i] = (rd_cdr && (32'(cdr_idx) == i))
                       || (rd_lcdr && (32'(last_ch_reg) == i));

    arf_flag u_done (
      .mclk_i (mclk_i),
      .srst_i (srst_i),
      .set_i  (conv_hit[i]),
      .clr_i  (done_clr[i]),
      .flag_o (done[i])
    );

    arf_flag u_ovr (
      .mclk_i (mclk_i),
      .srst_i (srst_i),
      .set_i  (conv_hit[i] && done[i]),
      .clr_i  (rd_over),
      .flag_o (ovr[i])
    );

    arf_flag u_ievt (
      .mclk_i (mclk_i),
      .srst_i (srst_i),
      .set_i  (conv_hit[i]),
      .clr_i  (rd_isr),
      .flag_o (istat[i])
    );
  end

  arf_flag u_ready (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .set_i  (conv_valid_i),
    .clr_i  (rd_lcdr),
    .flag_o (ready)
  );

  arf_flag u_gover (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .set_i  (conv_valid_i && ready),
    .clr_i  (rd_sr),
    .flag_o (gover)
  );

  arf_flag u_iready (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .set_i  (conv_valid_i),
    .clr_i  (rd_isr),
    .flag_o (istat[NCH])
  );

  arf_flag u_igover (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .set_i  (conv_valid_i && ready),
    .clr_i  (rd_isr),
    .flag_o (istat[NCH+1])
  );

  // read words
  // reduced mode hides the two top bits even of results stored before the switch
  wire logic [RES_W-1:0] keep_mask = {{(RES_W-LOW_W){!low_res_reg}}, {LOW_W{1'b1}}};
  wire logic [DW-1:0] mr_word  = DW'(low_res_reg) << LOW_RES_BIT;
  wire logic [DW-1:0] emr_word = DW'(tag_reg) << TAG_BIT;
  wire logic [DW-1:0] sr_word  = DW'(done) | (DW'(ready) << READY_BIT)
                                 | (DW'(gover) << GLOBAL_OVR_BIT);
  wire logic [DW-1:0] tag_word = tag_reg ? (DW'(last_ch_reg) << CHAN_NUM_LSB) : '0;
  wire logic [DW-1:0] lcd_word = DW'(last_val_reg & keep_mask) | tag_word;
  wire logic [DW-1:0] cdr_word = DW'(res_mem[cdr_idx] & keep_mask);
  wire logic [DW-1:0] rd_mux   = rd_mr   ? mr_word            :
                                 rd_emr  ? emr_word           :
                                 rd_sr   ? sr_word            :
                                 rd_lcdr ? lcd_word           :
                                 rd_imr  ? DW'(imask_reg)     :
                                 rd_isr  ? DW'(istat)         :
                                 rd_over ? DW'(ovr)           :
                                 rd_cdr  ? cdr_word           : '0;

  wire logic ready_rise = ready && !ready_q_reg;
  wire logic irq_next  = |(istat & imask_reg);

  // mode registers
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      low_res_reg <= LOW_RES_RST;
      tag_reg    <= TAG_RST;
      imask_reg  <= '0;
    end
    else
    begin
      if (wr_mr)
        low_res_reg <= bus_i.wdata[LOW_RES_BIT];
      if (wr_emr)
        tag_reg <= bus_i.wdata[TAG_BIT];
      if (wr_imr)
        imask_reg <= bus_i.wdata[IW-1:0];
    end
  end

  // result storage
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      for (int k = 0; k < NCH; k++)
        res_mem[k] <= '0;
      last_val_reg <= '0;
      last_ch_reg  <= '0;
    end
    else if (conv_valid_i)
    begin
      res_mem[conv_i.chan] <= fmt_res;
      last_val_reg <= fmt_res;
      last_ch_reg  <= conv_i.chan;
    end
  end

  // outputs
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      rdata_o    <= '0;
      irq_o      <= 1'b0;
      dma_req_o  <= 1'b0;
      dma_size_o <= 2'h0;
      ready_q_reg <= 1'b0;
    end
    else
    begin
      rdata_o    <= bus_i.rd ? rd_mux : '0;
      irq_o      <= irq_next;
      dma_req_o   <= ready_rise;
      dma_size_o  <= DMA_HALF;
      ready_q_reg <= ready;
    end
  end

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  property p_low_top;
    low_res_reg && conv_valid_i |=> last_val_reg == {2'h0, $past(conv_i.data[LOW_W-1:0])};
  endproperty
  a_low_top: assert property (p_low_top) else $error("reduced result misplaced");

  property p_low_read;
    low_res_reg && rd_lcdr |=> rdata_o[RES_W-1:LOW_W] == 2'h0;
  endproperty
  a_low_read: assert property (p_low_read) else $error("top result bits not zero");

  property p_cdr_low;
    low_res_reg && rd_cdr |=> rdata_o[RES_W-1:LOW_W] == 2'h0;
  endproperty
  a_cdr_low: assert property (p_cdr_low) else $error("channel result top bits not zero");

  property p_dma_size;
    $past(srst_i) == 1'b0 |-> dma_size_o == DMA_HALF;
  endproperty
  a_dma_size: assert property (p_dma_size) else $error("dma size not 16 bits");

  property p_store;
    conv_valid_i |=> res_mem[$past(conv_i.chan)] == last_val_reg
                     && last_ch_reg == $past(conv_i.chan)
                     && ($past(low_res_reg) || last_val_reg == $past(conv_i.data));
  endproperty
  a_store: assert property (p_store) else $error("result not stored");

  property p_tag;
    tag_reg && rd_lcdr && !conv_valid_i |=> rdata_o[CHAN_NUM_LSB+CH_W-1:CHAN_NUM_LSB] == last_ch_reg;
  endproperty
  a_tag: assert property (p_tag) else $error("channel tag wrong");

  property p_set;
    conv_valid_i |=> ready && done[$past(conv_i.chan)];
  endproperty
  a_set: assert property (p_set) else $error("done or ready not set");

  property p_dma;
    $rose(ready) |=> dma_req_o ##1 !dma_req_o;
  endproperty
  a_dma: assert property (p_dma) else $error("no dma request on ready rise");

  property p_irq;
    (istat & imask_reg) != '0 |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_low;
    (istat & imask_reg) == '0 |=> !irq_o;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt without unmasked event");

  property p_cdr_clr;
    rd_cdr && !conv_valid_i |=> !done[$past(cdr_idx)];
  endproperty
  a_cdr_clr: assert property (p_cdr_clr) else $error("done not cleared");

  property p_lcdr_clr;
    rd_lcdr && !conv_valid_i |=> !ready && !done[$past(last_ch_reg)];
  endproperty
  a_lcdr_clr: assert property (p_lcdr_clr) else $error("ready not cleared");

  property p_ovr;
    conv_valid_i && done[conv_i.chan] |=> ovr[$past(conv_i.chan)];
  endproperty
  a_ovr: assert property (p_ovr) else $error("channel overrun missed");

  property p_gover;
    conv_valid_i && ready |=> gover;
  endproperty
  a_gover: assert property (p_gover) else $error("global overrun missed");

  property p_over_clr;
    rd_over && !conv_valid_i |=> ovr == '0;
  endproperty
  a_over_clr: assert property (p_over_clr) else $error("overrun not cleared");

  property p_sr_clr;
    rd_sr && !(conv_valid_i && ready) |=> !gover;
  endproperty
  a_sr_clr: assert property (p_sr_clr) else $error("global overrun not cleared");

  property p_no_ovr;
    conv_valid_i && !done[conv_i.chan] && !ovr[conv_i.chan] && !rd_over
      |=> !ovr[$past(conv_i.chan)];
  endproperty
  a_no_ovr: assert property (p_no_ovr) else $error("false channel overrun");

  property p_set_wins;
    rd_lcdr && conv_valid_i |=> ready && done[$past(conv_i.chan)];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

  property p_reset_mode;
    $past(srst_i) |-> !low_res_reg && !tag_reg;
  endproperty
  a_reset_mode: assert property (@(posedge mclk_i) p_reset_mode) else $error("mode not reset");

  c_ovr:   cover property (conv_valid_i && done[conv_i.chan]);
  c_gover: cover property (conv_valid_i && ready && low_res_reg);
  c_dma:   cover property (dma_req_o ##1 rd_lcdr);
  c_wins:  cover property (rd_lcdr && conv_valid_i);
  c_tag:   cover property (tag_reg && rd_lcdr);

endmodule : arf_top
`default_nettype wire

/* File: inc/arf_pkg.sv */
// Purpose: shared constants and carriers of the converter result block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   offsets, field positions and reset values are named once here
package arf_pkg;

  localparam int unsigned AW     = 8;
  localparam int unsigned DW     = 32;
  localparam int unsigned RES_W  = 12;
  localparam int unsigned LOW_W  = 10;
  localparam int unsigned CH_W   = 4;

  // register offsets
  localparam logic [AW-1:0] MR_OFS   = 8'h04;
  localparam logic [AW-1:0] EMR_OFS  = 8'h08;
  localparam logic [AW-1:0] SR_OFS   = 8'h1c;
  localparam logic [AW-1:0] LCDR_OFS = 8'h20;
  localparam logic [AW-1:0] IMR_OFS  = 8'h2c;
  localparam logic [AW-1:0] ISR_OFS  = 8'h30;
  localparam logic [AW-1:0] OVER_OFS = 8'h3c;
  localparam logic [AW-1:0] CDR_BASE = 8'h50;

  // field positions
  localparam int unsigned LOW_RES_BIT    = 4;
  localparam int unsigned TAG_BIT        = 24;
  localparam int unsigned READY_BIT      = 16;
  localparam int unsigned GLOBAL_OVR_BIT = 17;
  localparam int unsigned CHAN_NUM_LSB   = 12;

  // reset values and dma transfer size
  localparam logic       LOW_RES_RST = 1'b0;
  localparam logic       TAG_RST     = 1'b0;
  localparam logic [1:0] DMA_HALF    = 2'h1;

  typedef struct packed {
    logic          rd;
    logic          wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } arf_bus_s;

  typedef struct packed {
    logic [CH_W-1:0]  chan;
    logic [RES_W-1:0] data;
  } arf_conv_s;

endpackage : arf_pkg

/* File: verilog/arf_flag.sv */
// Purpose: sticky flag, set by hardware and cleared by a register read
// Assumes: set and clear are one-cycle pulses on mclk_i
// Notes:   a set in the clearing cycle wins
`timescale 1ns/10ps
`default_nettype none
module arf_flag
(
  input  wire logic mclk_i,  // clock
  input  wire logic srst_i,  // sync reset
  input  wire logic set_i,   // event
  input  wire logic clr_i,   // read clear
  output var  logic flag_o   // flag state
);

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      flag_o <= 1'b0;
    else if (set_i)
      flag_o <= 1'b1;
    else if (clr_i)
      flag_o <= 1'b0;
  end

endmodule : arf_flag
`default_nettype wire

/* File: verilog/arf_fmt.sv */
// Purpose: shapes a raw conversion into the stored result field
// Assumes: the core delivers reduced results in the low bits
// Notes:   purely combinational
`timescale 1ns/10ps
`default_nettype none
module arf_fmt
  import arf_pkg::*;
#(
  parameter int unsigned FULL_W = RES_W,
  parameter int unsigned RED_W  = LOW_W
)
(
  input  wire logic              low_res_i, // reduced mode
  input  wire logic [FULL_W-1:0] raw_i,     // raw result
  output wire logic [FULL_W-1:0] res_o      // stored value
);

  wire logic [FULL_W-1:0] red_val = {{(FULL_W-RED_W){1'b0}}, raw_i[RED_W-1:0]};

  assign res_o = low_res_i ? red_val : raw_i;

endmodule : arf_fmt
`default_nettype wire

/* File: tb/arf_core_model.sv */
// Purpose: behavioural conversion core feeding finished results to the block
// Assumes: one result per valid pulse, driven just after a rising edge
// Notes:   result lines change while idle so stale data never looks valid
`timescale 1ns/10ps
`default_nettype none
module arf_core_model
  import arf_pkg::*;
(
  input  wire logic      mclk_i,        // clock
  output var  logic      conv_valid_o,  // conversion done pulse
  output var  arf_conv_s conv_o         // channel and raw result
);
  initial
  begin
    conv_valid_o = 1'b0;
    conv_o       = '0;
  end

  // gap idles the core before the result, to answer slowly
  task automatic convert(input logic [CH_W-1:0] ch, input logic [RES_W-1:0] v, input int gap);
    repeat (gap) @(posedge mclk_i);
    @(posedge mclk_i);
    conv_valid_o <= 1'b1;
    conv_o       <= '{chan: ch, data: v};
    @(posedge mclk_i);
    conv_valid_o <= 1'b0;
    conv_o       <= ~conv_o;
  endtask : convert
endmodule : arf_core_model
`default_nettype wire

/* File: tb/adc_result_register_flags_test.sv */
// Purpose: self-checking bench of the converter result block
// Assumes: one clock, sync reset, register reads answer one cycle later
// Notes:   expected words are built from the flag behaviour, never from the design
`timescale 1ns/10ps
`default_nettype none
module adc_result_register_flags_test
  import arf_pkg::*;
;
  logic          mclk_i;
  logic          srst_i;
  arf_bus_s      bus_i;
  logic [DW-1:0] rdata_o;
  logic          conv_valid_i;
  arf_conv_s     conv_i;
  logic          irq_o;
  logic          dma_req_o;
  logic [1:0]    dma_size_o;
  logic [DW-1:0] d;
  int            failures;
  int            num_checks;
  int            cyc;

  arf_top #(.NCH(16)) dut_u
  (
    .mclk_i       (mclk_i),
    .srst_i       (srst_i),
    .bus_i        (bus_i),
    .rdata_o      (rdata_o),
    .conv_valid_i (conv_valid_i),
    .conv_i       (conv_i),
    .irq_o        (irq_o),
    .dma_req_o    (dma_req_o),
    .dma_size_o   (dma_size_o)
  );

  arf_core_model core_u
  (
    .mclk_i       (mclk_i),
    .conv_valid_o (conv_valid_i),
    .conv_o       (conv_i)
  );

  initial mclk_i = 1'b0;
  always #2.5 mclk_i = ~mclk_i;

  task automatic test_done();
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge mclk_i);
    bus_i <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
    @(posedge mclk_i);
    bus_i <= '0;
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] v);
    @(posedge mclk_i);
    bus_i <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: '0};
    @(posedge mclk_i);
    bus_i <= '0;
    #1 v = rdata_o;
  endtask : rd

  task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] exp);
    logic [DW-1:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rc

  // hang guard, the whole sequence needs under a hundred cycles
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      test_done();
    end
  end

  initial
  begin
    srst_i     = 1'b1;
    bus_i      = '0;
    failures   = 0;
    num_checks = 0;
    cyc        = 0;
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk({30'h0, dma_size_o}, 32'h1);
    rc(MR_OFS, 32'h0);
    rc(8'h44, 32'h0);
    // full resolution, flags, dma and interrupt
    wr(IMR_OFS, 32'h0001_0000);
    core_u.convert(4'h3, 12'habc, 3);
    @(posedge mclk_i);
    #1 chk({31'h0, dma_req_o}, 32'h1);
    chk({31'h0, irq_o}, 32'h1);
    @(posedge mclk_i);
    #1 chk({31'h0, dma_req_o}, 32'h0);
    rc(SR_OFS, 32'h0001_0008);
    rc(CDR_BASE + 8'h0c, 32'h0000_0abc);
    rc(LCDR_OFS, 32'h0000_0abc);
    rc(SR_OFS, 32'h0);
    rc(ISR_OFS, 32'h0001_0008);
    @(posedge mclk_i);
    #1 chk({31'h0, irq_o}, 32'h0);
    // channel tag in the last result
    wr(EMR_OFS, 32'h0100_0000);
    core_u.convert(4'h5, 12'h123, 0);
    rc(LCDR_OFS, 32'h0000_5123);
    rc(SR_OFS, 32'h0);
    // channel and global overrun
    core_u.convert(4'h2, 12'h111, 0);
    core_u.convert(4'h2, 12'h222, 0);
    rc(OVER_OFS, 32'h0000_0004);
    rc(OVER_OFS, 32'h0);
    rc(SR_OFS, 32'h0003_0004);
    rc(SR_OFS, 32'h0001_0004);
    rc(CDR_BASE + 8'h08, 32'h0000_0222);
    rc(LCDR_OFS, 32'h0000_2222);
    // reduced resolution
    wr(MR_OFS, 32'h0000_0010);
    rc(MR_OFS, 32'h0000_0010);
    core_u.convert(4'h1, 12'hfff, 0);
    rc(CDR_BASE + 8'h04, 32'h0000_03ff);
    rc(LCDR_OFS, 32'h0000_13ff);
    rc(SR_OFS, 32'h0);
    chk({30'h0, dma_size_o}, 32'h1);
    // read clear meets a new result on the same channel
    core_u.convert(4'h7, 12'h055, 0);
    fork
      core_u.convert(4'h7, 12'h066, 0);
      rd(CDR_BASE + 8'h1c, d);
    join
    chk(d, 32'h0000_0055);
    rc(SR_OFS, 32'h0003_0080);
    rc(OVER_OFS, 32'h0000_0080);
    chk({31'h0, irq_o}, 32'h1);
    wr(IMR_OFS, 32'h0);
    @(posedge mclk_i);
    #1 chk({31'h0, irq_o}, 32'h0);
    test_done();
  end
endmodule : adc_result_register_flags_test
`default_nettype wire
